// ===== core/owd_watchdog.sv
// How it works
// - Counting and overflow only after enable bit 5 is set by firmware or the power-up strap.
// - Counter advances once every twelve times prescaler clock cycles.
// - Fifteen-bit free-running counter fed through an eight-bit prescaler.
// - Writing one to bit 4 restarts the count; zero does nothing.
// - Overflow asserts the CPU reset output.
// - Enable stays set until power-on reset.
// - Control survives every reset except power-on, which loads 0x00.
// - Overflow sets flag bit 7 until firmware clears it.
// - In idle, counting continues only when bit 3 is set.
// - Select code n divides by two to the power n plus one.
// - Control register is write-only; it reads as zero.
// - Enable, idle bit and select load from option straps at power-up.
// - Overflow period is full counter range times tick interval.
`timescale 1ns/1ps
`default_nettype none

module owd_watchdog #(
    parameter int unsigned OVERFLOW_COUNT = owd_pkg::OVERFLOW_COUNT
) (
    // Clock and power-on reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_n_i,
    // Avalon-MM slave
    input  wire logic [owd_pkg::ADDR_W-1:0]    avs_address_i,
    input  wire logic                          avs_read_i,
    input  wire logic                          avs_write_i,
    input  wire logic [owd_pkg::DATA_W-1:0]    avs_writedata_i,
    input  wire logic [3:0]                    avs_byteenable_i,
    output logic      [owd_pkg::DATA_W-1:0]    avs_readdata_o,
    output logic                               avs_waitrequest_o,
    // CPU power state and reset
    input  wire logic                          cpu_idle_i,
    input  wire logic                          cpu_power_down_i,
    output logic                               cpu_reset_o,
    // Nonvolatile option straps
    input  wire logic                          option_enable_at_powerup_i,
    input  wire logic                          option_idle_count_i,
    input  wire logic [owd_pkg::SEL_W-1:0]     option_divide_select_i,
    // Interrupt
    output logic                               irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    localparam logic [owd_pkg::COUNT_W-1:0] COUNT_LAST =
        owd_pkg::COUNT_W'(OVERFLOW_COUNT - 1);

    logic                          ack_reg;
    logic [owd_pkg::DATA_W-1:0]    readdata_reg;
    logic [1:0]                    opt_cnt_reg;
    logic                          count_enable_sticky_reg;
    logic                          count_in_idle_reg;
    logic [owd_pkg::SEL_W-1:0]     divide_select_reg;
    logic                          overflow_reset_flag_reg;
    logic [owd_pkg::COUNT_W-1:0]   count_reg;
    logic [owd_pkg::HOLD_W-1:0]    reset_hold_reg;
    logic [owd_pkg::IRQ_W-1:0]     irq_status_reg;
    logic [owd_pkg::IRQ_W-1:0]     irq_enable_reg;

    logic [4:0]                    opt_sync;
    logic                          opt_load;
    logic                          wr_take;
    logic                          rd_start;
    logic                          wr_ctrl;
    logic                          wr_irq_clear;
    logic                          wr_irq_enable;
    logic [7:0]                    wbyte;
    logic                          count_restart;
    logic                          run;
    logic                          tick;
    logic                          overflow;
    logic [owd_pkg::IRQ_W-1:0]     irq_events;
    logic [owd_pkg::DATA_W-1:0]    readdata_next;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait state on every access

    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;
    assign wr_take           = avs_write_i && ack_reg;
    assign rd_start          = avs_read_i && !ack_reg;
    assign wbyte             = avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00;

    assign wr_ctrl       = wr_take && avs_byteenable_i[0]
                           && owd_pkg::addr_hit(avs_address_i, owd_pkg::CTRL_IDX);
    assign wr_irq_clear  = wr_take && avs_byteenable_i[0]
                           && owd_pkg::addr_hit(avs_address_i, owd_pkg::IRQ_CLEAR_IDX);
    assign wr_irq_enable = wr_take && avs_byteenable_i[0]
                           && owd_pkg::addr_hit(avs_address_i, owd_pkg::IRQ_ENABLE_IDX);

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            ack_reg <= 1'b0;
        else
            ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
    end

    always_comb
    begin
        readdata_next = '0;
        if (owd_pkg::addr_hit(avs_address_i, owd_pkg::STATE_IDX))
        begin
            readdata_next[owd_pkg::CTRL_FLAG_BIT]   = overflow_reset_flag_reg;
            readdata_next[owd_pkg::CTRL_ENABLE_BIT] = count_enable_sticky_reg;
            readdata_next[owd_pkg::CTRL_IDLE_BIT]   = count_in_idle_reg;
            readdata_next[owd_pkg::CTRL_SEL_LSB +: owd_pkg::SEL_W] = divide_select_reg;
        end
        else if (owd_pkg::addr_hit(avs_address_i, owd_pkg::COUNT_IDX))
            readdata_next[owd_pkg::COUNT_W-1:0] = count_reg;
        else if (owd_pkg::addr_hit(avs_address_i, owd_pkg::IRQ_STATUS_IDX))
            readdata_next[owd_pkg::IRQ_W-1:0] = irq_status_reg;
        else if (owd_pkg::addr_hit(avs_address_i, owd_pkg::IRQ_ENABLE_IDX))
            readdata_next[owd_pkg::IRQ_W-1:0] = irq_enable_reg;
        // Control and unmapped addresses read as zero
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            readdata_reg <= '0;
        else if (rd_start)
            readdata_reg <= readdata_next;
    end

    assign avs_readdata_o = readdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Option straps, caught after the power-on reset is released

    owd_sync #(
        .W (5)
    ) u_opt_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i ({option_enable_at_powerup_i, option_idle_count_i,
                   option_divide_select_i}),
        .sync_o  (opt_sync)
    );

    assign opt_load = (opt_cnt_reg == owd_pkg::OPT_LOAD_AT);

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            opt_cnt_reg <= 2'h0;
        else if (opt_cnt_reg != owd_pkg::OPT_LOAD_DONE)
            opt_cnt_reg <= opt_cnt_reg + 2'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register; only the power-on reset touches it

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            count_enable_sticky_reg <= owd_pkg::CTRL_RESET[owd_pkg::CTRL_ENABLE_BIT];
        else if (opt_load && opt_sync[4])
            count_enable_sticky_reg <= 1'b1;
        else if (wr_ctrl && wbyte[owd_pkg::CTRL_ENABLE_BIT])
            count_enable_sticky_reg <= 1'b1;
        // No path clears it short of power-on reset
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            count_in_idle_reg <= owd_pkg::CTRL_RESET[owd_pkg::CTRL_IDLE_BIT];
            divide_select_reg <= owd_pkg::CTRL_RESET[owd_pkg::SEL_W-1:0];
        end
        else if (wr_ctrl)
        begin
            count_in_idle_reg <= wbyte[owd_pkg::CTRL_IDLE_BIT];
            divide_select_reg <= wbyte[owd_pkg::CTRL_SEL_LSB +: owd_pkg::SEL_W];
        end
        else if (opt_load)
        begin
            count_in_idle_reg <= opt_sync[3];
            divide_select_reg <= opt_sync[2:0];
        end
    end

    // Overflow wins over a clearing write in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            overflow_reset_flag_reg <= owd_pkg::CTRL_RESET[owd_pkg::CTRL_FLAG_BIT];
        else if (overflow)
            overflow_reset_flag_reg <= 1'b1;
        else if (wr_ctrl && !wbyte[owd_pkg::CTRL_FLAG_BIT])
            overflow_reset_flag_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counting chain

    assign count_restart = wr_ctrl && wbyte[owd_pkg::CTRL_RESTART_BIT];
    assign run = count_enable_sticky_reg && !cpu_power_down_i
                 && (!cpu_idle_i || count_in_idle_reg);

    owd_prescale u_prescale (
        .clk_i           (clk_i),
        .rst_n_i         (rst_n_i),
        .run_i           (run),
        .restart_i       (count_restart),
        .divide_select_i (divide_select_reg),
        .tick_o          (tick)
    );

    // Restart in the overflow cycle saves the chip
    assign overflow = tick && (count_reg == COUNT_LAST);

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || count_restart)
            count_reg <= '0;
        else if (tick)
            count_reg <= (count_reg == COUNT_LAST) ? '0 : count_reg + 15'h0001;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            reset_hold_reg <= '0;
        else if (overflow)
            reset_hold_reg <= owd_pkg::HOLD_W'(owd_pkg::CPU_RESET_CYCLES);
        else if (reset_hold_reg != '0)
            reset_hold_reg <= reset_hold_reg - 4'h1;
    end

    assign cpu_reset_o = (reset_hold_reg != '0);

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky status, write-one clear, set wins

    assign irq_events[owd_pkg::IRQ_OVERFLOW_BIT] = overflow;
    assign irq_events[owd_pkg::IRQ_RESTART_BIT]  = count_restart;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            irq_status_reg <= owd_pkg::IRQ_RESET;
        else if (wr_irq_clear)
            irq_status_reg <= (irq_status_reg & ~wbyte[owd_pkg::IRQ_W-1:0]) | irq_events;
        else
            irq_status_reg <= irq_status_reg | irq_events;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            irq_enable_reg <= owd_pkg::IRQ_RESET;
        else if (wr_irq_enable)
            irq_enable_reg <= wbyte[owd_pkg::IRQ_W-1:0];
    end

    assign irq_o = |(irq_status_reg & irq_enable_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_idle_disabled: assert property (
        !count_enable_sticky_reg |-> !tick && !overflow && !cpu_reset_o)
        else $error("watchdog moved while disabled");

    a_tick_advance: assert property (
        (tick && !count_restart && count_reg != COUNT_LAST)
        |=> count_reg == $past(count_reg) + 15'h0001)
        else $error("counter did not advance on tick");

    a_count_range: assert property (
        count_reg <= COUNT_LAST)
        else $error("counter beyond its range");

    a_restart_zero: assert property (
        count_restart |=> count_reg == '0 && !cpu_reset_o [*2])
        else $error("restart did not zero the count");

    a_overflow_reset: assert property (
        overflow |=> cpu_reset_o [*4] ##1 !cpu_reset_o || overflow)
        else $error("overflow reset pulse wrong");

    a_enable_sticky: assert property (
        count_enable_sticky_reg |=> count_enable_sticky_reg)
        else $error("enable cleared without power-on reset");

    a_flag_set: assert property (
        overflow |=> overflow_reset_flag_reg)
        else $error("overflow flag not set");

    a_idle_pause: assert property (
        (cpu_idle_i && !count_in_idle_reg && !count_restart) |=> $stable(count_reg))
        else $error("counter moved during idle");

    a_power_hold: assert property (
        (cpu_power_down_i && !count_restart) |=> $stable(count_reg) && !$past(overflow))
        else $error("counter moved during power-down");

    a_ctrl_reads_zero: assert property (
        (rd_start && owd_pkg::addr_hit(avs_address_i, owd_pkg::CTRL_IDX))
        |=> avs_readdata_o == '0)
        else $error("control register not write-only");

    a_option_load: assert property (
        opt_load && !wr_ctrl |=> count_in_idle_reg == $past(opt_sync[3]))
        else $error("option strap not loaded");

    a_enable_source: assert property (
        (!count_enable_sticky_reg && !(wr_ctrl && wbyte[owd_pkg::CTRL_ENABLE_BIT])
         && !(opt_load && opt_sync[4])) |=> !count_enable_sticky_reg)
        else $error("enable set without a write or strap");

    // A control write without the restart bit must leave the count alone
    a_restart_zero_write: assert property (
        (wr_ctrl && !wbyte[owd_pkg::CTRL_RESTART_BIT] && !tick) |=> $stable(count_reg))
        else $error("restart bit zero moved the count");

    a_flag_hold: assert property (
        (overflow_reset_flag_reg && !(wr_ctrl && !wbyte[owd_pkg::CTRL_FLAG_BIT]))
        |=> overflow_reset_flag_reg)
        else $error("overflow flag dropped without a clearing write");

    a_option_enable: assert property (
        (opt_load && opt_sync[4]) |=> count_enable_sticky_reg)
        else $error("enable strap not loaded");

    c_overflow: cover property (overflow);
    c_power_hold: cover property (cpu_power_down_i && count_enable_sticky_reg);
    c_restart: cover property (count_restart && count_reg != '0);
    c_idle_count: cover property (cpu_idle_i && count_in_idle_reg && tick);
    c_irq: cover property (irq_o);

endmodule : owd_watchdog

`default_nettype wire

// ===== core/owd_pkg.sv
package owd_pkg;

    // Bus and register map, byte address is four times the index
    localparam int unsigned ADDR_W          = 12;
    localparam int unsigned DATA_W          = 32;
    localparam logic [7:0]  CTRL_IDX        = 8'he1;
    localparam logic [7:0]  STATE_IDX       = 8'he2;
    localparam logic [7:0]  COUNT_IDX       = 8'he3;
    localparam logic [7:0]  IRQ_STATUS_IDX  = 8'he4;
    localparam logic [7:0]  IRQ_CLEAR_IDX   = 8'he5;
    localparam logic [7:0]  IRQ_ENABLE_IDX  = 8'he6;

    // Control field positions
    localparam int unsigned CTRL_FLAG_BIT    = 7;
    localparam int unsigned CTRL_ENABLE_BIT  = 5;
    localparam int unsigned CTRL_RESTART_BIT = 4;
    localparam int unsigned CTRL_IDLE_BIT    = 3;
    localparam int unsigned CTRL_SEL_LSB     = 0;
    localparam int unsigned SEL_W            = 3;
    localparam logic [7:0]  CTRL_RESET       = 8'h00;

    // Interrupt layout
    localparam int unsigned IRQ_W            = 2;
    localparam int unsigned IRQ_OVERFLOW_BIT = 0;
    localparam int unsigned IRQ_RESTART_BIT  = 1;
    localparam logic [1:0]  IRQ_RESET        = 2'h0;

    // Counting chain
    localparam int unsigned STAGE_W          = 4;
    localparam logic [3:0]  BASE_LAST        = 4'hb;
    localparam int unsigned PRESCALE_W       = 8;
    localparam int unsigned COUNT_W          = 15;
    localparam int unsigned OVERFLOW_COUNT   = 32768;

    // Timing
    localparam int unsigned CLK_PERIOD_PS     = 4000;
    localparam int unsigned CPU_RESET_NS      = 16;
    localparam int unsigned CPU_RESET_CYCLES  =
        (CPU_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned HOLD_W            = 4;
    localparam logic [1:0]  OPT_LOAD_AT       = 2'h2;
    localparam logic [1:0]  OPT_LOAD_DONE     = 2'h3;

    // Last prescaler state for a select code: divide is 2 << sel
    function automatic logic [PRESCALE_W-1:0] prescale_last(input logic [SEL_W-1:0] sel);
        logic [PRESCALE_W:0] div;
        div = 9'h002 << sel;
        prescale_last = PRESCALE_W'(div - 9'h001);
    endfunction : prescale_last

    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        addr_hit = (addr == {2'h0, idx, 2'h0});
    endfunction : addr_hit

endpackage : owd_pkg

// ===== core/owd_sync.sv
`timescale 1ns/1ps
`default_nettype none

module owd_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // First stage feeds only the second
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule : owd_sync

`default_nettype wire

// ===== core/owd_prescale.sv
`timescale 1ns/1ps
`default_nettype none

module owd_prescale (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_n_i,
    // Control
    input  wire logic                          run_i,
    input  wire logic                          restart_i,
    input  wire logic [owd_pkg::SEL_W-1:0]     divide_select_i,
    // Count enable towards the watchdog counter
    output logic                               tick_o
);

    logic [owd_pkg::STAGE_W-1:0]    stage_reg;
    logic [owd_pkg::PRESCALE_W-1:0] pre_reg;
    logic                           stage_wrap;
    logic                           pre_wrap;

    assign stage_wrap = (stage_reg == owd_pkg::BASE_LAST);
    assign pre_wrap   = (pre_reg >= owd_pkg::prescale_last(divide_select_i));
    assign tick_o     = run_i && stage_wrap && pre_wrap && !restart_i;

    // Fixed divide by twelve, then the selectable prescaler
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || restart_i)
        begin
            stage_reg <= '0;
            pre_reg   <= '0;
        end
        else if (run_i)
        begin
            stage_reg <= stage_wrap ? '0 : stage_reg + 4'h1;
            if (stage_wrap)
            begin
                // Shrinking the select mid-count must not strand the count
                pre_reg <= pre_wrap ? '0 : pre_reg + 8'h01;
            end
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_tick_position: assert property (
        tick_o |-> (stage_reg == owd_pkg::BASE_LAST)
                   && (pre_reg >= owd_pkg::prescale_last(divide_select_i)))
        else $error("tick outside the last prescale state");

    a_hold_stopped: assert property (
        (!run_i && !restart_i) |=> $stable(stage_reg) && $stable(pre_reg))
        else $error("prescaler moved while stopped");

endmodule : owd_prescale

`default_nettype wire

// ===== tb/owd_watchdog_tb.sv
`timescale 1ns/1ps
`default_nettype none

module owd_watchdog_tb;

    // Short overflow range keeps the slowest divide inside the run
    localparam int OVF = 4;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] addr = 12'h000;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be = 4'h0;
    logic [31:0] rdata;
    logic        wreq;
    logic        idle = 1'b0;
    logic        pdn = 1'b0;
    logic        cpu_rst;
    logic        irq;
    logic        opt_en = 1'b0;
    logic        opt_idle = 1'b0;
    logic [2:0]  opt_sel = 3'h0;
    int          n_rst = 0;
    int          n_base = 0;
    logic [31:0] q;
    int          err_count = 0;
    int          n_compared = 0;
    int          cyc = 0;

    always #2 clk = ~clk;

    owd_watchdog #(
        .OVERFLOW_COUNT(OVF)
    ) dut (
        .clk_i                      (clk),
        .rst_n_i                    (rst_n),
        .avs_address_i              (addr),
        .avs_read_i                 (rd),
        .avs_write_i                (wr),
        .avs_writedata_i            (wdata),
        .avs_byteenable_i           (be),
        .avs_readdata_o             (rdata),
        .avs_waitrequest_o          (wreq),
        .cpu_idle_i                 (idle),
        .cpu_power_down_i           (pdn),
        .cpu_reset_o                (cpu_rst),
        .option_enable_at_powerup_i (opt_en),
        .option_idle_count_i        (opt_idle),
        .option_divide_select_i     (opt_sel),
        .irq_o                      (irq)
    );

    ////////////////////////////////////////////////////////////////////////////////

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // Request held until waitrequest is sampled low at a rising edge
    task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       input logic [3:0] b);
        @(posedge clk);
        addr  <= {2'h0, idx, 2'h0};
        wr    <= w;
        rd    <= !w;
        wdata <= {24'h0, d};
        be    <= b;
        @(posedge clk);
        // Only the bench timeout ends a wait that never answers
        while (wreq !== 1'b0)
            @(posedge clk);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : acc

    task automatic wr8(input logic [7:0] idx, input logic [7:0] d);
        acc(1'b1, idx, d, 4'h1);
    endtask : wr8

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string m);
        acc(1'b0, idx, 8'h00, 4'hf);
        chk(q, exp, m);
    endtask : rdc

    // Edges from the last write until the CPU reset shows, then its width
    task automatic ovf(input int p, input string m);
        int n;
        int w;
        n = 0;
        w = 0;
        @(negedge clk);
        while (cpu_rst !== 1'b1 && n < p + 20)
        begin
            @(negedge clk);
            n++;
        end
        chk({31'h0, n >= p && n <= p + 2}, 32'h1, m);
        while (cpu_rst === 1'b1 && w < 20)
        begin
            @(negedge clk);
            w++;
        end
        chk(w, 4, "reset width");
    endtask : ovf

    always @(posedge clk)
    begin
        if (cpu_rst === 1'b1)
            n_rst++;
        cyc++;
        if (cyc == 60000)
        begin
            err_count++;
            $display("mismatch at %0t: timeout", $time);
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rdc(owd_pkg::STATE_IDX, 32'h0, "state at reset");
        rdc(owd_pkg::CTRL_IDX, 32'h0, "control reads");
        rdc(8'h10, 32'h0, "unmapped");
        rdc(owd_pkg::IRQ_ENABLE_IDX, 32'h0, "irq enable");
        repeat (300) @(posedge clk);
        rdc(owd_pkg::COUNT_IDX, 32'h0, "idle count");
        chk(n_rst, 0, "reset while off");
        $display("test disabled done");

        wr8(owd_pkg::IRQ_ENABLE_IDX, 8'h01);
        rdc(owd_pkg::IRQ_ENABLE_IDX, 32'h1, "irq enable rw");
        for (int s = 0; s < 8; s++)
        begin
            wr8(owd_pkg::CTRL_IDX, 8'h30 | 8'(s));
            ovf(OVF * 12 * (2 << s), "period");
            rdc(owd_pkg::STATE_IDX, 32'ha0 | s, "flag kept");
        end
        wr8(owd_pkg::CTRL_IDX, 8'hb7);
        rdc(owd_pkg::STATE_IDX, 32'ha7, "flag write one");
        chk(irq, 1'b1, "irq on overflow");
        rdc(owd_pkg::IRQ_STATUS_IDX, 32'h3, "irq status");
        wr8(owd_pkg::IRQ_CLEAR_IDX, 8'h03);
        rdc(owd_pkg::IRQ_STATUS_IDX, 32'h0, "irq cleared");
        chk(irq, 1'b0, "irq low");
        wr8(owd_pkg::IRQ_ENABLE_IDX, 8'h00);
        wr8(owd_pkg::CTRL_IDX, 8'h30);
        rdc(owd_pkg::STATE_IDX, 32'h20, "flag cleared");
        chk(irq, 1'b0, "irq masked");
        wr8(owd_pkg::IRQ_ENABLE_IDX, 8'h02);
        rdc(owd_pkg::IRQ_STATUS_IDX, 32'h2, "restart event");
        chk(irq, 1'b1, "irq unmasked");
        wr8(owd_pkg::IRQ_CLEAR_IDX, 8'h02);
        rdc(owd_pkg::IRQ_STATUS_IDX, 32'h0, "restart cleared");
        chk(irq, 1'b0, "irq low again");
        $display("test divide and irq done");

        wr8(owd_pkg::CTRL_IDX, 8'h30);
        n_base = n_rst;
        repeat (6)
        begin
            repeat (60) @(posedge clk);
            wr8(owd_pkg::CTRL_IDX, 8'h30);
        end
        chk(n_rst - n_base, 0, "kept alive");
        repeat (40) @(posedge clk);
        wr8(owd_pkg::CTRL_IDX, 8'h20);
        ovf(OVF * 24 - 43, "zero restart bit");
        $display("test restart done");

        // Pins move on the rising edge only
        @(posedge clk);
        idle <= 1'b1;
        wr8(owd_pkg::CTRL_IDX, 8'h30);
        repeat (300) @(posedge clk);
        rdc(owd_pkg::COUNT_IDX, 32'h0, "paused in idle");
        wr8(owd_pkg::CTRL_IDX, 8'h38);
        ovf(OVF * 24, "count in idle");
        @(posedge clk);
        idle <= 1'b0;
        pdn  <= 1'b1;
        wr8(owd_pkg::CTRL_IDX, 8'h30);
        n_base = n_rst;
        repeat (300) @(posedge clk);
        rdc(owd_pkg::COUNT_IDX, 32'h0, "frozen");
        chk(n_rst - n_base, 0, "no overflow frozen");
        pdn <= 1'b0;
        $display("test idle and power-down done");

        acc(1'b1, owd_pkg::CTRL_IDX, 8'h07, 4'h0);
        rdc(owd_pkg::STATE_IDX, 32'h20, "no lane write");
        wr8(owd_pkg::CTRL_IDX, 8'h00);
        rdc(owd_pkg::STATE_IDX, 32'h20, "enable sticky");
        $display("test sticky done");

        @(posedge clk);
        rst_n    <= 1'b0;
        opt_en   <= 1'b1;
        opt_idle <= 1'b1;
        opt_sel  <= 3'h5;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rdc(owd_pkg::STATE_IDX, 32'h2d, "straps loaded");
        $display("test power-up done");
        results();
    end

endmodule : owd_watchdog_tb

`default_nettype wire
